// ===== verilog/itoc_defines.svh
// Operation
// - Thermal trip time 5*tm*K^M over (I/In)^M
// - K is 3 for phase, 1 for ground
// - M is 0, 1, 2, 4 per thermal curve
// - Nominal current 1 A or 5 A by rating
// - Inverse time above pickup, capped at 40*In
// - Pickup setting clamped to at least 0.02*In
// - Thermal reset time is 45 times multiplier
// - Reset by curve, fixed delay, or instantly
// - Between pickup and cap, curve sets delay
// - Phase-to-phase wiring forces phase-to-phase restraint basis
// - Restraint enabled lowers pickup with phase voltage
// - Effective pickup is percent times setting, floored
// - Percent 25% at quarter Vmax, 100% at Vmax
// - Restraint touches pickup only, never the curves
// - Supervised breaker trip blocks the restrained element
// - Nominal voltage is rating over root three only for ground basis
// - Negative sequence mode compares I2 with threshold
// - I2 is third of I1 + a2*I2 + a*I3
// - Negative sequence shares all phase element settings
`ifndef ITOC_DEFINES_SVH
`define ITOC_DEFINES_SVH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define ITOC_ADDR_CTRL 8'h00
`define ITOC_ADDR_PICKUP 8'h04
`define ITOC_ADDR_TMULT 8'h08
`define ITOC_ADDR_RSTDLY 8'h0C
`define ITOC_ADDR_VTRATE 8'h10
`define ITOC_ADDR_STATUS 8'h14
`define ITOC_ADDR_OPVAL 8'h18
`define ITOC_RESP_OKAY 2'h0
`define ITOC_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ITOC_CLK_NS 20
`define ITOC_TICK_NS 1000000
`define ITOC_TICK_CYC (`ITOC_TICK_NS / `ITOC_CLK_NS)

// ---------------------------------------------------------------
// Curve and scaling constants
// ---------------------------------------------------------------
`define ITOC_K_PHASE 64'h3
`define ITOC_K_GROUND 64'h1
`define ITOC_TRIP_FACTOR 64'h5
`define ITOC_RESET_FACTOR 64'h2D
`define ITOC_PU_MAX 14'h2800
`define ITOC_RECIP_1A 23'h418937
`define ITOC_RECIP_5A 23'h0D1B71
`define ITOC_MIN_PK_1A 19'h00014
`define ITOC_MIN_PK_5A 19'h00064
`define ITOC_INV_SQRT3 36'sh0000093CD
`define ITOC_SQRT3_HALF 37'sh00000006EDA
`define ITOC_ONE_THIRD 38'sh0000005555

`endif

// ===== verilog/itoc_pkg.sv
package itoc_pkg;

	typedef enum logic [1:0] {
		ITOC_CURVE_FLAT = 2'h0,
		ITOC_CURVE_LINEAR = 2'h1,
		ITOC_CURVE_SQUARE = 2'h2,
		ITOC_CURVE_FOURTH = 2'h3
	} itoc_curve_t;

	typedef enum logic [1:0] {
		ITOC_RST_CURVE = 2'h0,
		ITOC_RST_FIXED = 2'h1,
		ITOC_RST_INSTANT = 2'h2
	} itoc_rmode_t;

	typedef enum logic [1:0] {
		ITOC_OPQ_PHASE = 2'h0,
		ITOC_OPQ_GROUND = 2'h1,
		ITOC_OPQ_NEGSEQ = 2'h2
	} itoc_opq_t;

	typedef enum logic [1:0] {
		ITOC_SQ_IDLE = 2'b01,
		ITOC_SQ_RUN = 2'b10
	} itoc_sq_state_t;

	// Control register layout, bit 0 at the bottom
	typedef struct packed {
		logic vts_enable;
		logic voltage_restraint_enable;
		logic meas_phase_phase;
		logic voltage_transformer_wiring;
		itoc_opq_t opq;
		logic current_transformer_rating;
		itoc_rmode_t rmode;
		itoc_curve_t curve;
		logic enable;
	} itoc_ctrl_t;

	// Measurement chain: magnitudes in mA / mV, phasors in mA
	typedef struct packed {
		logic [2:0][17:0] i_mag;
		logic [17:0] ig_mag;
		logic [2:0][17:0] i_re;
		logic [2:0][17:0] i_im;
		logic [2:0][17:0] v_pg;
		logic [2:0][17:0] v_pp;
	} itoc_meas_t;

endpackage : itoc_pkg

// ===== verilog/itoc_top.sv
`include "itoc_defines.svh"

module itoc_top
	import itoc_pkg::*;
#(
	parameter int TICK_CYCLES = `ITOC_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire itoc_meas_t meas,
	input wire logic vts_mcb_trip,
	output logic trip_out,
	output logic pickup_out
);

	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	itoc_ctrl_t ctrl_reg;
	logic [18:0] pickup_reg, vtrate_reg;
	logic [15:0] tmult_reg, rstdly_reg;
	logic trip_reg, pickup_st_reg, blocked_reg, resetting_reg;
	logic [18:0] op_reg;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	wire logic aw_fire = s_axi_awvalid & awready_reg;
	wire logic w_fire = s_axi_wvalid & wready_reg;
	wire logic ar_fire = s_axi_arvalid & arready_reg;
	wire logic write_go = ~awready_reg & ~wready_reg & ~bvalid_reg;

	wire logic [31:0] status_word = {28'h0, resetting_reg, blocked_reg, trip_reg, pickup_st_reg};

	function automatic logic [31:0] reg_value(input logic [7:0] a, input logic [31:0] stat,
		input logic [31:0] opv, input logic [31:0] c, input logic [31:0] p,
		input logic [31:0] t, input logic [31:0] r, input logic [31:0] v);
		case (a)
			`ITOC_ADDR_CTRL: return c;
			`ITOC_ADDR_PICKUP: return p;
			`ITOC_ADDR_TMULT: return t;
			`ITOC_ADDR_RSTDLY: return r;
			`ITOC_ADDR_VTRATE: return v;
			`ITOC_ADDR_STATUS: return stat;
			`ITOC_ADDR_OPVAL: return opv;
			default: return 32'h0;
		endcase
	endfunction : reg_value

	wire logic [31:0] ctrl_w = {20'h0, ctrl_reg};
	wire logic [31:0] pickup_w = {13'h0, pickup_reg};
	wire logic [31:0] tmult_w = {16'h0, tmult_reg};
	wire logic [31:0] rstdly_w = {16'h0, rstdly_reg};
	wire logic [31:0] vtrate_w = {13'h0, vtrate_reg};
	wire logic [31:0] opval_w = {13'h0, op_reg};
	wire logic [31:0] rd_value = reg_value(s_axi_araddr, status_word, opval_w, ctrl_w, pickup_w,
		tmult_w, rstdly_w, vtrate_w);
	wire logic [31:0] wr_old = reg_value(aw_addr_reg, status_word, opval_w, ctrl_w, pickup_w,
		tmult_w, rstdly_w, vtrate_w);
	wire logic [31:0] wr_new = merge(wr_old, w_data_reg, w_strb_reg);
	wire logic rd_mapped = s_axi_araddr inside {`ITOC_ADDR_CTRL, `ITOC_ADDR_PICKUP,
		`ITOC_ADDR_TMULT, `ITOC_ADDR_RSTDLY, `ITOC_ADDR_VTRATE, `ITOC_ADDR_STATUS,
		`ITOC_ADDR_OPVAL};
	wire logic wr_rw = aw_addr_reg inside {`ITOC_ADDR_CTRL, `ITOC_ADDR_PICKUP,
		`ITOC_ADDR_TMULT, `ITOC_ADDR_RSTDLY, `ITOC_ADDR_VTRATE};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `ITOC_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else begin
			if (aw_fire) begin
				awready_reg <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_fire) begin
				wready_reg <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (write_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_rw ? `ITOC_RESP_OKAY : `ITOC_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= '0;
			pickup_reg <= 19'h0;
			tmult_reg <= 16'h0;
			rstdly_reg <= 16'h0;
			vtrate_reg <= 19'h0;
		end else if (write_go) begin
			case (aw_addr_reg)
				`ITOC_ADDR_CTRL: ctrl_reg <= wr_new[11:0];
				`ITOC_ADDR_PICKUP: pickup_reg <= wr_new[18:0];
				`ITOC_ADDR_TMULT: tmult_reg <= wr_new[15:0];
				`ITOC_ADDR_RSTDLY: rstdly_reg <= wr_new[15:0];
				`ITOC_ADDR_VTRATE: vtrate_reg <= wr_new[18:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `ITOC_RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_value;
			rresp_reg <= rd_mapped ? `ITOC_RESP_OKAY : `ITOC_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Negative-sequence current
	// ---------------------------------------------------------------
	logic signed [17:0] ph_x [3];
	logic signed [17:0] ph_y [3];
	for (genvar g = 0; g < 3; g++) begin : g_ph
		assign ph_x[g] = meas.i_re[g];
		assign ph_y[g] = meas.i_im[g];
	end

	// Rotations by a and a^2 folded into one sum per axis
	wire logic signed [19:0] ns_dy = 20'(ph_y[1]) - 20'(ph_y[2]);
	wire logic signed [19:0] ns_dx = 20'(ph_x[2]) - 20'(ph_x[1]);
	wire logic signed [36:0] ns_pr = 37'(ns_dy) * `ITOC_SQRT3_HALF;
	wire logic signed [36:0] ns_pi = 37'(ns_dx) * `ITOC_SQRT3_HALF;
	wire logic signed [21:0] ns_re = 22'(ph_x[0]) - ((22'(ph_x[1]) + 22'(ph_x[2])) >>> 1)
		+ 22'(ns_pr >>> 15);
	wire logic signed [21:0] ns_im = 22'(ph_y[0]) - ((22'(ph_y[1]) + 22'(ph_y[2])) >>> 1)
		+ 22'(ns_pi >>> 15);
	wire logic signed [37:0] ns_re3 = (38'(ns_re) * `ITOC_ONE_THIRD) >>> 16;
	wire logic signed [37:0] ns_im3 = (38'(ns_im) * `ITOC_ONE_THIRD) >>> 16;
	wire logic signed [19:0] ns_a = 20'(ns_re3);
	wire logic signed [19:0] ns_b = 20'(ns_im3);
	wire logic [40:0] ns_sq = 41'(ns_a * ns_a) + 41'(ns_b * ns_b);

	// Bitwise square root gives the I2 magnitude in about 22 cycles
	itoc_sq_state_t sq_state_reg;
	logic [40:0] sq_val_reg;
	logic [20:0] root_reg, i2_mag_reg;
	logic [4:0] sq_bit_reg;
	wire logic [20:0] sq_trial = root_reg | (21'h1 << sq_bit_reg);
	wire logic [41:0] sq_trial2 = 42'(sq_trial) * 42'(sq_trial);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sq_state_reg <= ITOC_SQ_IDLE;
			sq_val_reg <= 41'h0;
			root_reg <= 21'h0;
			sq_bit_reg <= 5'h0;
			i2_mag_reg <= 21'h0;
		end else begin
			case (sq_state_reg)
				ITOC_SQ_IDLE: begin
					sq_val_reg <= ns_sq;
					root_reg <= 21'h0;
					sq_bit_reg <= 5'h14;
					sq_state_reg <= ITOC_SQ_RUN;
				end
				ITOC_SQ_RUN: begin
					if (sq_trial2 <= 42'(sq_val_reg)) begin
						root_reg <= sq_trial;
					end
					if (sq_bit_reg == 5'h0) begin
						i2_mag_reg <= (sq_trial2 <= 42'(sq_val_reg)) ? sq_trial : root_reg;
						sq_state_reg <= ITOC_SQ_IDLE;
					end else begin
						sq_bit_reg <= sq_bit_reg - 5'h1;
					end
				end
				default: sq_state_reg <= ITOC_SQ_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Operate quantity
	// ---------------------------------------------------------------
	wire logic [17:0] ph_max01 = (meas.i_mag[0] > meas.i_mag[1]) ? meas.i_mag[0] : meas.i_mag[1];
	wire logic [17:0] ph_max = (ph_max01 > meas.i_mag[2]) ? ph_max01 : meas.i_mag[2];
	wire logic [18:0] i2_sat = (i2_mag_reg > 21'h7FFFF) ? 19'h7FFFF : i2_mag_reg[18:0];
	// Negative sequence swaps only the measured quantity
	wire logic [18:0] op_ma = (ctrl_reg.opq == ITOC_OPQ_NEGSEQ) ? i2_sat :
		(ctrl_reg.opq == ITOC_OPQ_GROUND) ? {1'b0, meas.ig_mag} : {1'b0, ph_max};

	// ---------------------------------------------------------------
	// Pickup with voltage restraint
	// ---------------------------------------------------------------
	wire logic rating_5a = ctrl_reg.current_transformer_rating;
	wire logic [18:0] min_pk = rating_5a ? `ITOC_MIN_PK_5A : `ITOC_MIN_PK_1A;
	wire logic [18:0] pickup_c = (pickup_reg < min_pk) ? min_pk : pickup_reg;
	wire logic pp_basis = ctrl_reg.voltage_transformer_wiring | ctrl_reg.meas_phase_phase;
	wire logic [35:0] vt_div = (36'(vtrate_reg) * `ITOC_INV_SQRT3) >> 16;
	wire logic [18:0] nominal_voltage_ref = pp_basis ? vtrate_reg : vt_div[18:0];
	wire logic [2:0][17:0] v_sel = pp_basis ? meas.v_pp : meas.v_pg;
	wire logic [17:0] v_min01 = (v_sel[0] < v_sel[1]) ? v_sel[0] : v_sel[1];
	wire logic [18:0] v_meas = {1'b0, (v_min01 < v_sel[2]) ? v_min01 : v_sel[2]};
	wire logic [18:0] v_floor = nominal_voltage_ref >> 2;
	// Percent equals V/Vmax clamped to [25%,100%]; kept as a ratio to avoid a divide
	wire logic [18:0] v_clamp = (v_meas <= v_floor) ? v_floor :
		(v_meas >= nominal_voltage_ref) ? nominal_voltage_ref : v_meas;
	wire logic [37:0] lhs = 38'(op_ma) * 38'(nominal_voltage_ref);
	wire logic [37:0] rhs_pct = 38'(pickup_c) * 38'(v_clamp);
	wire logic [37:0] rhs_min = 38'(min_pk) * 38'(nominal_voltage_ref);
	wire logic [37:0] rhs = (rhs_pct < rhs_min) ? rhs_min : rhs_pct;
	wire logic restr_on = ctrl_reg.voltage_restraint_enable;
	// Restraint moves only the threshold; the timer path below never sees it
	wire logic above = restr_on ? (lhs > rhs) : (op_ma > pickup_c);
	wire logic blocked = ctrl_reg.enable & restr_on & ctrl_reg.vts_enable & vts_mcb_trip;
	wire logic active = ctrl_reg.enable & ~blocked;
	wire logic picked = active & above;

	// ---------------------------------------------------------------
	// Thermal timer
	// ---------------------------------------------------------------
	wire logic [41:0] pu_raw = (42'(op_ma) * 42'(rating_5a ? `ITOC_RECIP_5A : `ITOC_RECIP_1A)) >> 24;
	wire logic [13:0] pu = (pu_raw > 42'(`ITOC_PU_MAX)) ? `ITOC_PU_MAX : pu_raw[13:0];
	wire logic [27:0] pu2 = 28'(pu) * 28'(pu);
	wire logic [55:0] pu4 = 56'(pu2) * 56'(pu2);
	wire logic [63:0] k_val = (ctrl_reg.opq == ITOC_OPQ_GROUND) ? `ITOC_K_GROUND : `ITOC_K_PHASE;
	logic [63:0] pu_pow, c_val;
	always_comb begin
		// Slope M of 0, 1, 2, 4 with 8 fraction bits per power
		case (ctrl_reg.curve)
			ITOC_CURVE_FLAT: begin
				pu_pow = 64'h1;
				c_val = 64'h1;
			end
			ITOC_CURVE_LINEAR: begin
				pu_pow = 64'(pu);
				c_val = k_val << 8;
			end
			ITOC_CURVE_SQUARE: begin
				pu_pow = 64'(pu2);
				c_val = (k_val * k_val) << 16;
			end
			default: begin
				pu_pow = 64'(pu4);
				c_val = (k_val * k_val * k_val * k_val) << 32;
			end
		endcase
	end
	// Timer scaled by 45/5: trip at 45*tm*K^M, rise by 9*(I/In)^M per ms
	wire logic [63:0] rise_div = `ITOC_RESET_FACTOR / `ITOC_TRIP_FACTOR;
	wire logic [63:0] thr = `ITOC_RESET_FACTOR * 64'(tmult_reg) * c_val;
	wire logic [63:0] inc = rise_div * pu_pow;

	logic [15:0] tick_cnt_reg;
	logic [63:0] acc_reg;
	logic [15:0] rst_cnt_reg;
	wire logic tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
	wire logic [63:0] acc_sum = acc_reg + inc;

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_reg <= 16'h0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !active) begin
			acc_reg <= 64'h0;
			rst_cnt_reg <= 16'h0;
		end else if (tick && picked) begin
			acc_reg <= (acc_sum > thr || acc_sum < acc_reg) ? thr : acc_sum;
			rst_cnt_reg <= 16'h0;
		end else if (tick) begin
			case (ctrl_reg.rmode)
				ITOC_RST_CURVE: acc_reg <= (acc_reg > c_val) ? acc_reg - c_val : 64'h0;
				ITOC_RST_FIXED: begin
					if (rst_cnt_reg >= rstdly_reg) begin
						acc_reg <= 64'h0;
					end else begin
						rst_cnt_reg <= rst_cnt_reg + 16'h1;
					end
				end
				default: acc_reg <= 64'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_reg <= 1'b0;
			pickup_st_reg <= 1'b0;
			blocked_reg <= 1'b0;
			resetting_reg <= 1'b0;
			op_reg <= 19'h0;
		end else begin
			trip_reg <= picked & (acc_reg >= thr);
			pickup_st_reg <= picked;
			blocked_reg <= blocked;
			resetting_reg <= active & ~picked & (acc_reg != 64'h0);
			op_reg <= op_ma;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign trip_out = trip_reg;
	assign pickup_out = pickup_st_reg;

endmodule : itoc_top

// ===== sim/itoc_top_monitor.sv
// ----------------------------------------
// Bus handshake and trip decision checks
// ----------------------------------------
module itoc_monitor
	import itoc_pkg::*;
#(
	parameter int TICK_CYCLES = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic vts_mcb_trip,
	input wire logic trip_out,
	input wire logic pickup_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] ctrl_reg;
	wire logic wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == 8'h00;
	wire logic blk = ctrl_reg[10] && ctrl_reg[11] && vts_mcb_trip;
	wire logic off = !ctrl_reg[0];

	// Shadow of the control word, one cycle ahead of the block's own copy
	always_ff @(posedge aclk) begin
		if (!aresetn) ctrl_reg <= '0;
		else if (wr_ctrl) ctrl_reg <= s_axi_wdata[11:0];
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped early");
	a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while response pending");
	a_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready
		&& !s_axi_wready)) else $error("write response without taken request");
	a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid
		&& s_axi_arready)) else $error("read data without taken address");
	a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready
		&& s_axi_wready && !s_axi_bvalid) else $error("write channel not freed");
	a_trip_picked: assert property ($rose(trip_out) |-> pickup_out)
		else $error("trip without pickup");
	a_trip_drops: assert property ($fell(pickup_out) |=> !trip_out)
		else $error("trip held after pickup fell");
	a_block_quiet: assert property (blk [*4] |-> !pickup_out && !trip_out)
		else $error("blocked element still active");
	a_off_quiet: assert property (off [*4] |-> !pickup_out && !trip_out)
		else $error("disabled element still active");
endmodule : itoc_monitor

bind itoc_top itoc_monitor #(.TICK_CYCLES(TICK_CYCLES)) itoc_monitor_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .vts_mcb_trip(vts_mcb_trip), .trip_out(trip_out),
	.pickup_out(pickup_out)
);

// ===== sim/itoc_meas_model.sv
// ----------------------------------------
// Measurement front end and supervision
// ----------------------------------------
module itoc_meas_model
	import itoc_pkg::*;
(
	input wire logic aclk,
	output itoc_meas_t meas,
	output logic vts_mcb_trip
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		meas = '0;
		vts_mcb_trip = 1'b0;
	end

	task set_i(input int a, input int g);
		@(posedge aclk);
		meas.i_mag <= {36'h0, 18'(a)};
		meas.i_re <= {36'h0, 18'(a)};
		meas.i_im <= '0;
		meas.ig_mag <= 18'(g);
	endtask : set_i

	// Balanced set, rotation chosen by neg
	task set_seq(input int a, input bit neg);
		int h;
		h = a * 866 / 1000;
		@(posedge aclk);
		meas.i_mag <= {3{18'(a)}};
		meas.i_re <= {18'(-a / 2), 18'(-a / 2), 18'(a)};
		meas.i_im <= neg ? {18'(-h), 18'(h), 18'h0} : {18'(h), 18'(-h), 18'h0};
	endtask : set_seq

	task set_v(input int pg, input int pp);
		@(posedge aclk);
		meas.v_pg <= {3{18'(pg)}};
		meas.v_pp <= {3{18'(pp)}};
	endtask : set_v

	task set_vts(input logic v);
		@(posedge aclk);
		vts_mcb_trip <= v;
	endtask : set_vts
endmodule : itoc_meas_model

// ===== sim/itoc_tb_top.sv
module itoc_tb_top
	import itoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 20;
	logic aclk;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, trip_out, pickup_out, vts_mcb_trip;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rnd;
	itoc_meas_t meas;
	int n_errors = 0;
	int tests_run = 0;
	int seed = 32'h311c;
	int cyc = 0;
	int n;
	logic [33:0] exp_q[$];

	itoc_meas_model itoc_meas_model_inst (.aclk(aclk), .meas(meas), .vts_mcb_trip(vts_mcb_trip));
	itoc_top #(.TICK_CYCLES(TK)) itoc_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas(meas), .vts_mcb_trip(vts_mcb_trip), .trip_out(trip_out), .pickup_out(pickup_out));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic check(input string name, input logic [33:0] seen, input logic [33:0] expv);
		tests_run++;
		if (seen !== expv) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, expv, seen);
		end
	endtask : check

	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Answer watcher: oldest note against each bus answer
	// ----------------------------------------
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
		if ((rready && rvalid === 1'b1) || (bready && bvalid === 1'b1)) begin
			if (exp_q.size() == 0) check("spare answer", 34'h1, 34'h0);
			else check("bus answer", rready ? {rresp, rdata} : {bresp, 32'h0}, exp_q.pop_front());
		end
	end

	task bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [33:0] e);
		int k;
		exp_q.push_back(e);
		k = 0;
		@(posedge aclk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		do begin
			@(posedge aclk);
			k++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (!((bready && bvalid === 1'b1) || (rready && rvalid === 1'b1)) && k < 100);
		bready <= 1'b0;
		rready <= 1'b0;
		if (k >= 100) begin
			n_errors++;
			give_verdict();
		end
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF, 34'h0);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] v);
		bus(1'b0, a, '0, '0, {2'h0, v});
	endtask : rd

	task cfg(input logic [31:0] c, input logic [31:0] pk);
		wr(8'h04, pk);
		wr(8'h00, c);
	endtask : cfg

	task wt(input bit t, input logic lvl, input int lim);
		n = 0;
		while ((t ? trip_out : pickup_out) !== lvl && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask : wt

	task pk(input int i, input logic e);
		itoc_meas_model_inst.set_i(i, 0);
		repeat (4) @(posedge aclk);
		check("pickup", 34'(pickup_out), 34'(e));
	endtask : pk

	// Trip after tk ticks, then release at once
	task trip_time(input int i, input int g, input int tk);
		itoc_meas_model_inst.set_i(i, g);
		wt(1'b1, 1'b1, 5000);
		check("trip time", 34'(n >= (tk - 1) * TK && n <= (tk + 2) * TK), 34'h1);
		itoc_meas_model_inst.set_i(0, 0);
		wt(1'b1, 1'b0, 10);
		check("trip release", 34'(n <= 3), 34'h1);
		repeat (2 * TK) @(posedge aclk);
	endtask : trip_time

	task gap(input int tk);
		itoc_meas_model_inst.set_i(0, 0);
		repeat (tk * TK) @(posedge aclk);
		itoc_meas_model_inst.set_i(1500, 0);
		wt(1'b1, 1'b1, 5000);
	endtask : gap

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) bus(1'b0, 8'(a), '0, '0, (a == 28) ? {2'h2, 32'h0} : 34'h0);
		bus(1'b1, 8'h1C, 32'h5, 4'hF, {2'h2, 32'h0});
		bus(1'b1, 8'h14, 32'hF, 4'hF, {2'h2, 32'h0});
		rd(8'h14, 32'h0);
		rnd = $random(seed);
		wr(8'h00, rnd);
		rd(8'h00, rnd & 32'hFFF);
		wr(8'h04, 32'h12345);
		bus(1'b1, 8'h04, 32'hFFFFFFAB, 4'h1, 34'h0);
		rd(8'h04, 32'h123AB);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h7FFFF);
		wr(8'h08, 32'h1);
		wr(8'h0C, 32'h4);
		$display("test registers finished");
		// No inrush blocking here, so short delays are allowed
		for (int m = 0; m < 4; m++) begin
			cfg(32'h11 | 32'(m << 1), 32'd1000);
			trip_time(1500, 0, 5 << ((m == 3) ? 4 : m));
		end
		cfg(32'h73, 32'd200);
		trip_time(0, 2500, 10);
		cfg(32'h11, 32'd1000);
		itoc_meas_model_inst.set_i(1500, 0);
		wt(1'b1, 1'b1, 500);
		rd(8'h14, 32'h3);
		rd(8'h18, 32'd1500);
		cfg(32'h11, 32'd5);
		pk(15, 1'b0);
		pk(30, 1'b1);
		$display("test curves finished");
		cfg(32'h09, 32'd1000);
		gap(0);
		gap(2);
		check("fixed hold", 34'(n <= 4), 34'h1);
		gap(8);
		check("fixed clear", 34'(n >= 4 * TK), 34'h1);
		wr(8'h00, 32'h01);
		gap(9);
		check("curve drain", 34'(n <= 2 * TK + 4), 34'h1);
		gap(50);
		check("curve empty", 34'(n >= 4 * TK), 34'h1);
		$display("test reset modes finished");
		wr(8'h10, 32'd100000);
		itoc_meas_model_inst.set_v(100000, 50000);
		cfg(32'h511, 32'd2000);
		pk(1200, 1'b1);
		pk(900, 1'b0);
		itoc_meas_model_inst.set_v(100000, 10000);
		pk(600, 1'b1);
		pk(450, 1'b0);
		wr(8'h10, 32'd173205);
		itoc_meas_model_inst.set_v(50000, 100000);
		cfg(32'hE11, 32'd2000);
		pk(1100, 1'b0);
		pk(1200, 1'b1);
		cfg(32'hC11, 32'd2000);
		pk(900, 1'b0);
		pk(1100, 1'b1);
		itoc_meas_model_inst.set_vts(1'b1);
		repeat (4) @(posedge aclk);
		check("blocked", 34'(pickup_out), 34'h0);
		rd(8'h14, 32'h4);
		itoc_meas_model_inst.set_vts(1'b0);
		trip_time(1100, 0, 5);
		$display("test restraint finished");
		cfg(32'h91, 32'd500);
		itoc_meas_model_inst.set_seq(1000, 1'b1);
		wt(1'b0, 1'b1, 100);
		check("negseq pick", 34'(pickup_out), 34'h1);
		wt(1'b1, 1'b1, 500);
		check("negseq trip", 34'(n >= 3 * TK && n <= 7 * TK), 34'h1);
		itoc_meas_model_inst.set_seq(1000, 1'b0);
		wt(1'b0, 1'b0, 100);
		check("posseq quiet", 34'(pickup_out), 34'h0);
		$display("test negative sequence finished");
		give_verdict();
	end
endmodule : itoc_tb_top
